/* src/csr_pkg.sv */
// Package for the core special-function register block: addresses,
// status bit positions, reset values and instruction codes.
// Assumes an 8-bit data memory address space with two banks.
package csr_pkg;

	// Data memory addresses of the core registers (bank 0)
	localparam logic [7:0] A_IND0 = 8'h00;
	localparam logic [7:0] A_PTR0 = 8'h01;
	localparam logic [7:0] A_IND1 = 8'h02;
	localparam logic [7:0] A_PTR1 = 8'h03;
	localparam logic [7:0] A_BANK = 8'h04;
	localparam logic [7:0] A_WORK = 8'h05;
	localparam logic [7:0] A_JUMP = 8'h06;
	localparam logic [7:0] A_TLO = 8'h07;
	localparam logic [7:0] A_TRES = 8'h08;
	localparam logic [7:0] A_THI = 8'h09;
	localparam logic [7:0] A_STAT = 8'h0a;
	localparam logic [7:0] A_EVT = 8'h61;
	localparam logic [7:0] A_MASK = 8'h62;
	localparam logic [7:0] A_GP_BASE = 8'h80;
	localparam logic [7:0] A_B1_END = 8'hbf;

	// Status register bit positions
	localparam int B_C = 0;
	localparam int B_AC = 1;
	localparam int B_Z = 2;
	localparam int B_OV = 3;
	localparam int B_PDF = 4;
	localparam int B_TO = 5;

	// Event bit positions
	localparam int EV_TO = 0;
	localparam int EV_HALT = 1;
	localparam int EV_JUMP = 2;
	localparam int EV_W = 3;

	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [5:0] RST_STAT = 6'h00;
	localparam logic [2:0] RST_MASK = 3'h0;

	// Core operations driven by the instruction sequencer
	typedef enum logic [3:0] {
		OP_NONE = 4'h0,
		OP_ADD = 4'h1,
		OP_SUB = 4'h2,
		OP_AND = 4'h3,
		OP_OR = 4'h4,
		OP_XOR = 4'h5,
		OP_RLC = 4'h6,
		OP_RRC = 4'h7,
		OP_LOAD = 4'h8,
		OP_STORE = 4'h9,
		OP_TABRD = 4'ha,
		OP_GUARD_REFRESH = 4'hb,
		OP_HALT = 4'hc
	} csr_op_type;

endpackage

/* src/csr_core.sv */
// Core special-function registers: indirect ports, pointers, bank select,
// work register with ALU flags, jump low byte, lookup-table pointers,
// status register, event status and mask with one interrupt output.
// Assumes the instruction sequencer, watchdog and program memory run on clk.
// How it works
// [RULE1] Indirect port accesses go to pointer's address
// [RULE2] Port zero reaches bank 0 only
// [RULE3] Port one uses the bank select setting
// [RULE4] Port itself reads 00H, writes ignored
// [RULE5] Direct addresses always reach bank 0
// [RULE6] Pointers are ordinary read/write storage
// [RULE7] ALU results land in work register only
// [RULE8] Jump byte write jumps, adds dummy cycle
// [RULE9] Table read: high byte saved, low stored
// [RULE10] Status writes keep the two system flags
// [RULE11] Guard flag: set on timeout, refresh or halt clears
// [RULE12] Sleep flag: set by halt, refresh clears
// [RULE13] Carry from add, no-borrow, rotates
// [RULE14] Nibble carry from low nibble
// [RULE15] Zero flag tracks zero result
// [RULE16] Wrap flag: carry into differs carry out
// [RULE17] Status is never saved automatically
// [RULE18] Bank select bit 0 picks bank
// [RULE19] Bits 7:6 zero, system flags reset zero
//
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps

module csr_core #(
	parameter int PAGE_W = 8
) (
	input logic clk,
	input logic rst_n,
	input logic [7:0] addr,
	input logic [7:0] wdata,
	input logic wr,
	input logic rd,
	output logic [7:0] rdata,
	input logic op_valid,
	input csr_pkg::csr_op_type op,
	input logic [7:0] op_addr,
	input logic guard_timeout,
	input logic [PAGE_W-1:0] pc_page,
	output logic prog_req,
	output logic [15:0] prog_addr,
	input logic [15:0] prog_data,
	input logic prog_valid,
	output logic jump_req,
	output logic [PAGE_W+7:0] jump_target,
	output logic dummy_cycle,
	output logic [7:0] work_out,
	output logic [7:0] status_out,
	output logic irq
);
	import csr_pkg::*;

	typedef struct packed {
		logic [7:0] ptr0;
		logic [7:0] ptr1;
		logic bank;
		logic [7:0] work;
		logic [7:0] jlow;
		logic [7:0] tlo;
		logic [7:0] tres;
		logic [7:0] thi;
		logic [5:0] stat;
		logic [1:0][127:0][7:0] ram;
		logic [7:0] rdata;
		logic [EV_W-1:0] evt;
		logic [EV_W-1:0] mask;
		logic irq;
		logic jreq;
		logic [PAGE_W+7:0] jtgt;
		logic dummy;
		logic preq;
		logic [15:0] paddr;
		logic [8:0] pdest;
		logic ppend;
	} csr_state_type;

	csr_state_type q_reg;
	csr_state_type q_next;
	logic [7:0] alu_m;

	// Map a data address to {bank, address}, following the indirect ports
	function automatic logic [8:0] resolve(input logic [7:0] a);
		if (a == A_IND0) begin
			return {1'b0, q_reg.ptr0}; // RULE1 RULE2
		end else if (a == A_IND1) begin
			return {q_reg.bank, q_reg.ptr1}; // RULE1 RULE3 RULE18
		end else begin
			return {1'b0, a}; // RULE5
		end
	endfunction

	// Read one byte at a resolved location; ports and gaps read zero
	function automatic logic [7:0] rd_byte(input logic [8:0] ba);
		logic [7:0] a;
		a = ba[7:0];
		if (a >= A_GP_BASE) begin
			if (!ba[8] || a <= A_B1_END) begin
				return q_reg.ram[ba[8]][a[6:0]];
			end else begin
				return RST_BYTE;
			end
		end else if (ba[8]) begin
			return RST_BYTE;
		end else if (a == A_PTR0) begin
			return q_reg.ptr0; // RULE6
		end else if (a == A_PTR1) begin
			return q_reg.ptr1; // RULE6
		end else if (a == A_BANK) begin
			return {7'h00, q_reg.bank};
		end else if (a == A_WORK) begin
			return q_reg.work;
		end else if (a == A_JUMP) begin
			return q_reg.jlow;
		end else if (a == A_TLO) begin
			return q_reg.tlo;
		end else if (a == A_TRES) begin
			return q_reg.tres;
		end else if (a == A_THI) begin
			return q_reg.thi;
		end else if (a == A_STAT) begin
			return {2'b00, q_reg.stat}; // RULE19
		end else if (a == A_EVT) begin
			return {5'h00, q_reg.evt};
		end else if (a == A_MASK) begin
			return {5'h00, q_reg.mask};
		end else begin
			return RST_BYTE; // RULE4
		end
	endfunction

	// ALU operand, fetched directly or through an indirect port; a process, so that
	// it follows every register that the lookup functions read, not only op_addr
	always_comb begin
		alu_m = rd_byte(resolve(op_addr));
	end

	// Next-state logic for all registers
	always_comb begin
		logic w_en;
		logic [8:0] w_ba;
		logic [7:0] w_d;
		logic [7:0] mb;
		logic cin;
		logic [8:0] sum;
		logic [4:0] nib;
		logic [7:0] low7;
		logic [7:0] res;
		logic [EV_W-1:0] ev_set;
		w_en = 1'b0;
		w_ba = 9'h000;
		w_d = 8'h00;
		mb = 8'h00;
		cin = 1'b0;
		sum = 9'h000;
		nib = 5'h00;
		low7 = 8'h00;
		res = 8'h00;
		ev_set = '0;
		q_next = q_reg;
		q_next.jreq = 1'b0;
		q_next.preq = 1'b0;
		q_next.dummy = q_reg.jreq; // RULE8

		// One write channel; table data beats a store, a store beats software
		if (wr) begin
			w_en = 1'b1;
			w_ba = resolve(addr);
			w_d = wdata;
		end
		if (op_valid && op == OP_STORE) begin
			w_en = 1'b1;
			w_ba = resolve(op_addr);
			w_d = q_reg.work; // RULE7
		end
		if (q_reg.ppend && prog_valid) begin
			w_en = 1'b1;
			w_ba = q_reg.pdest;
			w_d = prog_data[7:0]; // RULE9
			q_next.tres = prog_data[15:8]; // RULE9
			q_next.ppend = 1'b0;
		end

		// Apply the write at its resolved location
		if (w_en && w_ba[7:0] >= A_GP_BASE) begin
			if (!w_ba[8] || w_ba[7:0] <= A_B1_END) begin
				q_next.ram[w_ba[8]][w_ba[6:0]] = w_d; // RULE3 RULE5
			end
		end else if (w_en && !w_ba[8]) begin
			if (w_ba[7:0] == A_PTR0) begin
				q_next.ptr0 = w_d; // RULE6
			end else if (w_ba[7:0] == A_PTR1) begin
				q_next.ptr1 = w_d; // RULE6
			end else if (w_ba[7:0] == A_BANK) begin
				q_next.bank = w_d[0]; // RULE18
			end else if (w_ba[7:0] == A_WORK) begin
				q_next.work = w_d;
			end else if (w_ba[7:0] == A_JUMP) begin
				q_next.jlow = w_d;
				q_next.jreq = 1'b1; // RULE8
				q_next.jtgt = {pc_page, w_d}; // RULE8
			end else if (w_ba[7:0] == A_TLO) begin
				q_next.tlo = w_d;
			end else if (w_ba[7:0] == A_TRES) begin
				q_next.tres = w_d;
			end else if (w_ba[7:0] == A_THI) begin
				q_next.thi = w_d;
			end else if (w_ba[7:0] == A_STAT) begin
				q_next.stat[B_OV:B_C] = w_d[B_OV:B_C]; // RULE10
			end else if (w_ba[7:0] == A_MASK) begin
				q_next.mask = w_d[EV_W-1:0];
			end
		end

		// ALU: subtraction adds the inverted operand plus one
		mb = (op == OP_SUB) ? ~alu_m : alu_m;
		cin = (op == OP_SUB);
		sum = {1'b0, q_reg.work} + {1'b0, mb} + {8'h00, cin};
		nib = {1'b0, q_reg.work[3:0]} + {1'b0, mb[3:0]} + {4'h0, cin};
		low7 = {1'b0, q_reg.work[6:0]} + {1'b0, mb[6:0]} + {7'h00, cin};
		res = sum[7:0];
		if (op_valid) begin
			case (op)
				OP_ADD, OP_SUB: begin
					q_next.work = res; // RULE7
					q_next.stat[B_C] = sum[8]; // RULE13
					q_next.stat[B_AC] = nib[4]; // RULE14
					q_next.stat[B_Z] = (res == 8'h00); // RULE15
					q_next.stat[B_OV] = low7[7] ^ sum[8]; // RULE16
				end
				OP_AND, OP_OR, OP_XOR: begin
					if (op == OP_AND) begin
						res = q_reg.work & alu_m;
					end else if (op == OP_OR) begin
						res = q_reg.work | alu_m;
					end else begin
						res = q_reg.work ^ alu_m;
					end
					q_next.work = res; // RULE7
					q_next.stat[B_Z] = (res == 8'h00); // RULE15
				end
				OP_RLC: begin
					q_next.work = {alu_m[6:0], q_reg.stat[B_C]}; // RULE7
					q_next.stat[B_C] = alu_m[7]; // RULE13
				end
				OP_RRC: begin
					q_next.work = {q_reg.stat[B_C], alu_m[7:1]}; // RULE7
					q_next.stat[B_C] = alu_m[0]; // RULE13
				end
				OP_LOAD: begin
					q_next.work = alu_m; // RULE7
				end
				OP_TABRD: begin
					q_next.preq = 1'b1;
					q_next.paddr = {q_reg.thi, q_reg.tlo}; // RULE9
					q_next.pdest = resolve(op_addr); // RULE9
					q_next.ppend = 1'b1;
				end
				OP_GUARD_REFRESH: begin
					q_next.stat[B_TO] = 1'b0; // RULE11
					q_next.stat[B_PDF] = 1'b0; // RULE12
				end
				OP_HALT: begin
					q_next.stat[B_TO] = 1'b0; // RULE11
					q_next.stat[B_PDF] = 1'b1; // RULE12
					ev_set[EV_HALT] = 1'b1;
				end
				default: begin
					// No-op and store leave work and flags alone; a bus write to work still lands
				end
			endcase
		end

		// A timeout beats any clear in the same cycle
		if (guard_timeout) begin
			q_next.stat[B_TO] = 1'b1; // RULE11
			ev_set[EV_TO] = 1'b1;
		end
		ev_set[EV_JUMP] = q_next.jreq;

		// Status is held only here; calls and interrupts never push it
		q_next.stat = q_next.stat; // RULE17

		// Read data for one cycle; reading event status clears it, new events win
		q_next.rdata = rd ? rd_byte(resolve(addr)) : 8'h00; // RULE4
		if (rd && resolve(addr) == {1'b0, A_EVT}) begin
			q_next.evt = '0;
		end
		q_next.evt = q_next.evt | ev_set;
		q_next.irq = |(q_next.evt & q_next.mask);
	end

	// State register; arithmetic flags have no defined power-on value, zero here
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q_reg <= '0; // RULE19
			q_reg.stat <= RST_STAT;
			q_reg.mask <= RST_MASK;
		end else begin
			q_reg <= q_next;
		end
	end

	// Outputs straight from the state register
	assign rdata = q_reg.rdata;
	assign prog_req = q_reg.preq;
	assign prog_addr = q_reg.paddr;
	assign jump_req = q_reg.jreq;
	assign jump_target = q_reg.jtgt;
	assign dummy_cycle = q_reg.dummy;
	assign work_out = q_reg.work;
	assign status_out = {2'b00, q_reg.stat};
	assign irq = q_reg.irq;

	// Checks
	a_ind0_redirect: assert property (@(posedge clk) disable iff (!rst_n) // RULE1
		wr && addr == A_IND0 && q_reg.ptr0 == A_GP_BASE && !op_valid && !q_reg.ppend
		|=> q_reg.ram[0][0] == $past(wdata)) else $error("indirect write missed its pointer target");
	a_ind1_bank: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
		rd && addr == A_IND1 && q_reg.bank && q_reg.ptr1 == A_GP_BASE
		|=> rdata == $past(q_reg.ram[1][0])) else $error("port one ignored bank select");
	a_port_zero: assert property (@(posedge clk) disable iff (!rst_n) // RULE4
		rd && addr == A_IND0 && (q_reg.ptr0 == A_IND0 || q_reg.ptr0 == A_IND1)
		|=> rdata == 8'h00) else $error("port read not zero");
	a_direct_bank: assert property (@(posedge clk) disable iff (!rst_n) // RULE5
		rd && addr == A_GP_BASE |=> rdata == $past(q_reg.ram[0][0])) else $error("direct read left bank 0");
	a_status_ro: assert property (@(posedge clk) disable iff (!rst_n) // RULE10
		wr && addr == A_STAT && !op_valid && !guard_timeout
		|=> status_out[5:4] == $past(status_out[5:4])) else $error("status write hit system flags");
	a_halt_flags: assert property (@(posedge clk) disable iff (!rst_n) // RULE12
		op_valid && op == OP_HALT && !guard_timeout
		|=> status_out[B_PDF] && !status_out[B_TO]) else $error("halt flags wrong");
	a_timeout_set: assert property (@(posedge clk) disable iff (!rst_n) // RULE11
		guard_timeout |=> status_out[B_TO]) else $error("timeout flag not set");
	a_jump_dummy: assert property (@(posedge clk) disable iff (!rst_n) // RULE8
		wr && addr == A_JUMP && !op_valid && !q_reg.ppend
		|=> jump_req && jump_target == {$past(pc_page), $past(wdata)} ##1 dummy_cycle && !jump_req)
		else $error("jump or dummy cycle wrong");
	a_add_carry: assert property (@(posedge clk) disable iff (!rst_n) // RULE13
		op_valid && op == OP_ADD
		|=> status_out[B_C] == $past(({1'b0, q_reg.work} + {1'b0, alu_m}) > 9'h0ff)) else $error("carry wrong");
	a_and_work: assert property (@(posedge clk) disable iff (!rst_n) // RULE7
		op_valid && op == OP_AND
		|=> work_out == $past(q_reg.work & alu_m) && status_out[B_Z] == (work_out == 8'h00))
		else $error("logic result or zero flag wrong");
	a_table_high: assert property (@(posedge clk) disable iff (!rst_n) // RULE9
		q_reg.ppend && prog_valid |=> q_reg.tres == $past(prog_data[15:8])) else $error("table high byte lost");
	a_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
		guard_timeout && q_reg.mask[EV_TO] |=> irq) else $error("interrupt not raised");

endmodule // csr_core

/* testbench/csr_core_tb_top.sv */
// Self-checking bench for the core special-function register block.
// Assumes csr_pkg and csr_core are compiled first; one 40 MHz clock, async reset.
`timescale 1ns/100ps

module csr_core_tb_top;
	import csr_pkg::*;

	logic clk, rst_n, wr, rd, op_valid, guard_timeout, prog_valid;
	logic [7:0] addr, wdata, op_addr, pc_page, rdata, work_out, status_out, d;
	csr_op_type op;
	logic [15:0] prog_data, prog_addr, jump_target;
	logic prog_req, jump_req, dummy_cycle, irq;
	logic [11:0] r;
	logic [7:0] tw [4] = '{8'h7f, 8'hff, 8'h05, 8'h00};
	logic [7:0] tm [4] = '{8'h01, 8'h01, 8'h05, 8'h01};
	int fail_count = 0;
	int num_checks = 0;

	csr_core csr_core_inst (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .op_valid(op_valid), .op(op), .op_addr(op_addr), .guard_timeout(guard_timeout),
		.pc_page(pc_page), .prog_req(prog_req), .prog_addr(prog_addr), .prog_data(prog_data),
		.prog_valid(prog_valid), .jump_req(jump_req), .jump_target(jump_target),
		.dummy_cycle(dummy_cycle), .work_out(work_out), .status_out(status_out), .irq(irq));

	// Clock generator
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Verdict and end of run
	task automatic final_report;
		$display("checks=%0d mismatches=%0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// One-cycle register write
	task automatic wreg(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// One-cycle read, data sampled in the following cycle
	task automatic rreg(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] v;
		rreg(a, v);
		chk(v, exp);
	endtask

	// One instruction on the sequencer port; results settle after the edge
	task automatic do_op(input csr_op_type o, input logic [7:0] a);
		@(posedge clk);
		op <= o;
		op_addr <= a;
		op_valid <= 1'b1;
		@(posedge clk);
		op_valid <= 1'b0;
		#1;
	endtask

	// Watchdog time-out pulse
	task automatic pulse_to;
		@(posedge clk);
		guard_timeout <= 1'b1;
		@(posedge clk);
		guard_timeout <= 1'b0;
		#1;
	endtask

	// Reference adder: returns {result, ov, z, ac, c}
	function automatic logic [11:0] alu(input logic [7:0] a, input logic [7:0] b, input logic ci);
		logic [8:0] s;
		logic [4:0] h;
		logic [7:0] l;
		s = a + b + ci;
		h = a[3:0] + b[3:0] + ci;
		l = a[6:0] + b[6:0] + ci;
		return {s[7:0], l[7] ^ s[8], s[7:0] == 8'h00, h[4], s[8]};
	endfunction

	// Hang guard
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		final_report();
	end

	// Main sequence
	initial begin
		{rst_n, wr, rd, op_valid, guard_timeout, prog_valid} = 6'h00;
		{addr, wdata, op_addr} = 24'h000000;
		op = OP_NONE;
		pc_page = 8'h12;
		prog_data = 16'h0000;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1;
		chk(status_out, 8'h00);
		chk(irq, 1'b0);
		// Pointers and indirect ports
		wreg(A_PTR0, 8'h80);
		rchk(A_PTR0, 8'h80);
		wreg(A_IND0, 8'h5a);
		rchk(8'h80, 8'h5a);
		rchk(A_IND0, 8'h5a);
		wreg(A_PTR0, A_IND0);
		wreg(A_IND0, 8'h77);
		rchk(A_IND0, 8'h00);
		rchk(A_PTR0, 8'h00);
		wreg(A_BANK, 8'h01);
		wreg(A_PTR1, 8'h80);
		wreg(A_IND1, 8'hc3);
		rchk(A_IND1, 8'hc3);
		rchk(8'h80, 8'h5a);
		wreg(A_PTR0, 8'h80);
		rchk(A_IND0, 8'h5a);
		wreg(A_BANK, 8'h00);
		rchk(A_IND1, 8'h5a);
		wreg(8'h30, 8'h11);
		rchk(8'h30, 8'h00);
		// Add and subtract flags
		for (int i = 0; i < 4; i++) begin
			wreg(8'h80, tw[i]);
			wreg(8'h81, tm[i]);
			do_op(OP_LOAD, 8'h80);
			if (i < 2) begin
				do_op(OP_ADD, 8'h81);
			end else begin
				do_op(OP_SUB, 8'h81);
			end
			r = (i < 2) ? alu(tw[i], tm[i], 1'b0) : alu(tw[i], ~tm[i], 1'b1);
			chk(work_out, r[11:4]);
			chk(status_out, {4'h0, r[3:0]});
		end
		// Logic ops, rotates and store
		wreg(8'h80, 8'h0f);
		wreg(8'h81, 8'hf0);
		do_op(OP_LOAD, 8'h80);
		do_op(OP_AND, 8'h81);
		chk({work_out, 7'h00, status_out[B_Z]}, 16'h0001);
		do_op(OP_OR, 8'h81);
		chk({work_out, 7'h00, status_out[B_Z]}, 16'hf000);
		do_op(OP_XOR, 8'h81);
		chk({work_out, 7'h00, status_out[B_Z]}, 16'h0001);
		wreg(A_STAT, 8'h01);
		do_op(OP_RLC, 8'h81);
		chk({work_out, 7'h00, status_out[B_C]}, 16'he101);
		do_op(OP_RRC, 8'h81);
		chk({work_out, 7'h00, status_out[B_C]}, 16'hf800);
		do_op(OP_STORE, 8'h82);
		rchk(8'h82, 8'hf8);
		// System flags
		wreg(A_STAT, 8'hff);
		rchk(A_STAT, 8'h0f);
		do_op(OP_HALT, 8'h00);
		chk(status_out, 8'h1f);
		wreg(A_STAT, 8'h00);
		rchk(A_STAT, 8'h10);
		pulse_to();
		chk(status_out[5:4], 2'b11);
		do_op(OP_HALT, 8'h00);
		chk(status_out[5:4], 2'b01);
		pulse_to();
		do_op(OP_GUARD_REFRESH, 8'h00);
		chk(status_out[5:4], 2'b00);
		// Interrupt and jump
		rreg(A_EVT, d);
		wreg(A_MASK, 8'h04);
		pulse_to();
		@(posedge clk);
		#1;
		chk(irq, 1'b0);
		wreg(A_JUMP, 8'h5a);
		#1;
		chk({jump_req, jump_target}, 17'h1125a);
		@(posedge clk);
		#1;
		chk({dummy_cycle, jump_req}, 2'b10);
		@(posedge clk);
		#1;
		chk(irq, 1'b1);
		rreg(A_EVT, d);
		chk(d[2:0], 3'h5);
		@(posedge clk);
		#1;
		chk(irq, 1'b0);
		// Table read
		wreg(A_TLO, 8'h34);
		wreg(A_THI, 8'h12);
		do_op(OP_TABRD, 8'h83);
		chk({prog_req, prog_addr}, 17'h11234);
		@(posedge clk);
		prog_valid <= 1'b1;
		prog_data <= 16'habcd;
		@(posedge clk);
		prog_valid <= 1'b0;
		rchk(A_TRES, 8'hab);
		rchk(8'h83, 8'hcd);
		final_report();
	end
endmodule // csr_core_tb_top
